//--- rtl/asp_consts.svh
// Overview of operation
// - Select low: fixed bridge start-up interval of 420 ms before output enables.
// - Select high: fixed start-up interval of 800 ms before output enables, for single-ended loads.
// - Float request low immediately puts all half-bridges in high impedance.
// - Reset low ramps outputs to ground unless float is requested, and enters the low-power state.
// - A detected output short immediately disables output drive.
// - Short shutdown stays latched until reset is cycled low then high.
// - Fault output goes low on a short and stays low while latched.
// - Fault output released only on reset rising edge after a low phase.
// - Die temperature above 150 C shuts down with outputs disabled.
// - Thermal shutdown is not latched; recovers after 20 C cooling by itself.
// - Thermal shutdown never drives the fault output.
// - Warning output goes low when temperature reaches 125 C.
// - Warning returns high after about 20 C cooling, no reset needed.
// - Supply below about 8.4 V turns the device off as undervoltage.
// - Supply above about 27.5 V turns the device off as overvoltage.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_CLOCK_HZ        25000000
`define ASP_BTL_STARTUP_MS  420
`define ASP_SE_STARTUP_MS   800
`define ASP_BTL_STARTUP_CYC ((`ASP_CLOCK_HZ / 1000) * `ASP_BTL_STARTUP_MS)
`define ASP_SE_STARTUP_CYC  ((`ASP_CLOCK_HZ / 1000) * `ASP_SE_STARTUP_MS)
`define ASP_CNT_W           32
`endif

//--- rtl/asp_pkg.sv
package asp_pkg;
   typedef enum logic [1:0] {
      ASP_LOWPWR  = 2'b00,
      ASP_STARTUP = 2'b01,
      ASP_RUN     = 2'b10,
      ASP_LATCHED = 2'b11
   } asp_state_t;
endpackage

//--- rtl/asp_startup_timer.sv
`timescale 1ns/10ps
`include "asp_consts.svh"
module asp_startup_timer #(
   parameter int unsigned BTL_CYC = `ASP_BTL_STARTUP_CYC,
   parameter int unsigned SE_CYC  = `ASP_SE_STARTUP_CYC
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic run,
   input  wire logic output_config_select,
   output logic      done
);
   typedef struct packed {
      logic [`ASP_CNT_W-1:0] count;
      logic                  done;
   } asp_timer_t;
   asp_timer_t cur;
   asp_timer_t next_cur;
   logic [`ASP_CNT_W-1:0] limit;

   // Interval chosen by the select level; a change mid-count takes effect at once
   always_comb begin
      limit = output_config_select ? `ASP_CNT_W'(SE_CYC) : `ASP_CNT_W'(BTL_CYC);
      next_cur = cur;
      next_cur.done = 1'b0;
      if (start) begin
         next_cur.count = '0;
      end else if (run) begin
         if (cur.count + `ASP_CNT_W'(1) >= limit) begin
            next_cur.done = 1'b1;
         end else begin
            next_cur.count = cur.count + `ASP_CNT_W'(1);
         end
      end
   end

   // Register the timer state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign done = cur.done;
endmodule

//--- rtl/asp_protection_control.sv
`timescale 1ns/10ps
`include "asp_consts.svh"
module asp_protection_control #(
   parameter int unsigned BTL_CYC = `ASP_BTL_STARTUP_CYC,
   parameter int unsigned SE_CYC  = `ASP_SE_STARTUP_CYC
) (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic amp_reset_n,
   input  wire logic output_config_select,
   input  wire logic output_float_request_n,
   input  wire logic short_detect,
   input  wire logic over_temp_trip,
   input  wire logic temp_warn_level,
   input  wire logic undervoltage_shutdown,
   input  wire logic overvoltage_shutdown,
   output logic      bridge_drive_enable,
   output logic      bridge_float,
   output logic      output_ramp_to_ground,
   output logic      low_power,
   output logic      fault_n,
   output logic      over_temp_warning_n
);
   typedef struct packed {
      asp_pkg::asp_state_t state;
      logic                amp_reset_q;
      logic                drive;
      logic                float_out;
      logic                ramp_gnd;
      logic                low_pwr;
      logic                fault_n;
      logic                warn_n;
   } asp_ctl_t;
   asp_ctl_t cur;
   asp_ctl_t next_cur;
   logic [1:0] rst_sync;
   logic       rst_n;
   logic       timer_start;
   logic       timer_run;
   logic       timer_done;
   logic       inhibit;

   // Reset release through two flops so the design leaves reset cleanly
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   asp_startup_timer #(
      .BTL_CYC (BTL_CYC),
      .SE_CYC  (SE_CYC)
   ) u_timer (
      .clock                (clock),
      .rst_n                (rst_n),
      .start                (timer_start),
      .run                  (timer_run),
      .output_config_select (output_config_select),
      .done                 (timer_done)
   );

   // Thermal and supply conditions stop drive but never latch
   assign inhibit = over_temp_trip | undervoltage_shutdown | overvoltage_shutdown;

   // Sequencer: low power, start-up ramp, run, latched short
   always_comb begin
      next_cur = cur;
      next_cur.amp_reset_q = amp_reset_n;
      timer_start = 1'b0;
      timer_run   = 1'b0;
      case (cur.state)
         asp_pkg::ASP_LOWPWR: begin
            if (amp_reset_n && !inhibit) begin
               next_cur.state = asp_pkg::ASP_STARTUP;
               timer_start = 1'b1;
            end
         end
         asp_pkg::ASP_STARTUP: begin
            timer_run = 1'b1;
            if (inhibit) begin
               // Restart the ramp after a thermal or supply dropout
               next_cur.state = asp_pkg::ASP_LOWPWR;
            end else if (timer_done) begin
               next_cur.state = asp_pkg::ASP_RUN;
            end
         end
         asp_pkg::ASP_RUN: begin
            if (inhibit) begin
               next_cur.state = asp_pkg::ASP_LOWPWR;
            end
         end
         asp_pkg::ASP_LATCHED: begin
            // Only a reset cycle leaves; thermal recovery has no say here
            if (!amp_reset_n) begin
               next_cur.state = asp_pkg::ASP_LATCHED;
            end else if (!cur.amp_reset_q) begin
               next_cur.state = asp_pkg::ASP_LOWPWR;
            end
         end
         default: begin
            next_cur.state = asp_pkg::ASP_LOWPWR;
         end
      endcase
      // Short detection with reset high wins over everything; a short in the release cycle latches again
      if (short_detect && amp_reset_n) begin
         next_cur.state = asp_pkg::ASP_LATCHED;
      end
      // Reset low forces low power unless a short is latched
      if (!amp_reset_n && next_cur.state != asp_pkg::ASP_LATCHED) begin
         next_cur.state = asp_pkg::ASP_LOWPWR;
      end
      // Outputs decoded from next state and inputs so they leave straight from flops
      next_cur.drive     = (next_cur.state == asp_pkg::ASP_RUN) && output_float_request_n;
      next_cur.float_out = !output_float_request_n;
      next_cur.ramp_gnd  = !amp_reset_n && output_float_request_n;
      next_cur.low_pwr   = !amp_reset_n;
      next_cur.fault_n   = (next_cur.state != asp_pkg::ASP_LATCHED);
      // Hysteresis of the warning lives in the analog comparator
      next_cur.warn_n    = !temp_warn_level;
   end

   // Register all control state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{state: asp_pkg::ASP_LOWPWR, amp_reset_q: 1'b0, drive: 1'b0,
                  float_out: 1'b0, ramp_gnd: 1'b1, low_pwr: 1'b1,
                  fault_n: 1'b1, warn_n: 1'b1};
      end else begin
         cur <= next_cur;
      end
   end

   assign bridge_drive_enable   = cur.drive;
   assign bridge_float          = cur.float_out;
   assign output_ramp_to_ground = cur.ramp_gnd;
   assign low_power             = cur.low_pwr;
   assign fault_n               = cur.fault_n;
   assign over_temp_warning_n   = cur.warn_n;

   // Float request removes drive on the next edge
   property p_float_kills_drive;
      @(posedge clock) disable iff (!rst_n)
      !output_float_request_n |=> bridge_float && !bridge_drive_enable;
   endproperty
   a_float_kills_drive: assert property (p_float_kills_drive)
      else $error("float request did not float bridges");

   // Short while driving drops drive and pulls fault low
   property p_short_disables;
      @(posedge clock) disable iff (!rst_n)
      short_detect && amp_reset_n |=> !bridge_drive_enable && !fault_n;
   endproperty
   a_short_disables: assert property (p_short_disables)
      else $error("short did not disable drive and flag fault");

   // Fault held low while reset stays high; the release edge itself is excluded
   property p_fault_held;
      @(posedge clock) disable iff (!rst_n)
      !fault_n && amp_reset_n && $past(amp_reset_n) |=> !fault_n;
   endproperty
   a_fault_held: assert property (p_fault_held)
      else $error("fault released without reset cycle");

   // Fault released after reset rises from low
   property p_fault_release;
      @(posedge clock) disable iff (!rst_n)
      !fault_n && !amp_reset_n ##1 amp_reset_n && !short_detect |=> fault_n;
   endproperty
   a_fault_release: assert property (p_fault_release)
      else $error("fault not released on reset rising edge");

   // Thermal trip never changes the fault output
   property p_thermal_no_fault;
      @(posedge clock) disable iff (!rst_n)
      over_temp_trip && !short_detect && fault_n |=> fault_n;
   endproperty
   a_thermal_no_fault: assert property (p_thermal_no_fault)
      else $error("thermal trip reported on fault output");

   // Any inhibit condition removes drive
   property p_inhibit_off;
      @(posedge clock) disable iff (!rst_n)
      inhibit |=> !bridge_drive_enable;
   endproperty
   a_inhibit_off: assert property (p_inhibit_off)
      else $error("drive enabled during thermal or supply fault");

   // Reset low means low power and no bridge drive
   property p_reset_lowpower;
      @(posedge clock) disable iff (!rst_n)
      !amp_reset_n |=> low_power && !bridge_drive_enable;
   endproperty
   a_reset_lowpower: assert property (p_reset_lowpower)
      else $error("reset low did not enter low power");

   // Warning follows the temperature flag one edge later
   property p_warn_follow;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |=> over_temp_warning_n == !$past(temp_warn_level);
   endproperty
   a_warn_follow: assert property (p_warn_follow)
      else $error("warning output does not track temperature");

   // Drive only comes up after a start-up interval
   property p_drive_after_startup;
      @(posedge clock) disable iff (!rst_n)
      $rose(bridge_drive_enable) |-> $past(cur.state) != asp_pkg::ASP_LOWPWR;
   endproperty
   a_drive_after_startup: assert property (p_drive_after_startup)
      else $error("drive enabled without start-up interval");

   // A latched short keeps the bridges off whatever the temperature does
   property p_latched_no_drive;
      @(posedge clock) disable iff (!rst_n)
      !fault_n |-> !bridge_drive_enable;
   endproperty
   a_latched_no_drive: assert property (p_latched_no_drive)
      else $error("drive enabled while short is latched");

   // Once every condition has cleared, a new start-up begins with no outside help
   property p_recover_restart;
      @(posedge clock) disable iff (!rst_n)
      cur.state == asp_pkg::ASP_LOWPWR && amp_reset_n && !inhibit && !short_detect
         |=> cur.state == asp_pkg::ASP_STARTUP;
   endproperty
   a_recover_restart: assert property (p_recover_restart)
      else $error("no restart after conditions cleared");
endmodule

//--- verif/asp_pwm_host.sv
`timescale 1ns/10ps
// Processor side model: owns the amplifier reset and float pins
module asp_pwm_host (
   input  wire logic clock,
   input  wire logic want_run,
   input  wire logic want_float,
   input  wire logic supply_falling,
   output logic      amp_reset_n,
   output logic      output_float_request_n
);
   // Reset sits low from power-up, so the amplifier starts in its quiet state;
   // a request that is not a clean one keeps the pin low, never left floating
   initial begin
      amp_reset_n = 1'b0;
      forever begin
         @(posedge clock);
         amp_reset_n <= (want_run === 1'b1);
      end
   end
   // Float ahead of lockout when the supply collapses, so power-down stays silent
   assign output_float_request_n = !(want_float === 1'b1 || supply_falling === 1'b1);
endmodule

//--- verif/asp_protection_control_bench.sv
`timescale 1ns/10ps
module asp_protection_control_bench;
   // Short start-up counts keep the run brief
   localparam int BTL = 20;
   localparam int SE  = 40;
   logic clock = 1'b0, resetn = 1'b0, want_run = 1'b0, want_float = 1'b0, cfg = 1'b0;
   logic short_det = 1'b0, ot_trip = 1'b0, warn_lvl = 1'b0, uv = 1'b0, ov = 1'b0;
   logic amp_reset_n, float_n, drive, flt, ramp, lowp, fault_n, warn_n;
   int   n_fail = 0, check_count = 0, cnt;

   always #20 clock = ~clock;

   asp_pwm_host host (.clock(clock), .want_run(want_run), .want_float(want_float),
      .supply_falling(uv), .amp_reset_n(amp_reset_n), .output_float_request_n(float_n));

   asp_protection_control #(.BTL_CYC(BTL), .SE_CYC(SE)) dut (.clock(clock), .resetn(resetn),
      .amp_reset_n(amp_reset_n), .output_config_select(cfg), .output_float_request_n(float_n),
      .short_detect(short_det), .over_temp_trip(ot_trip), .temp_warn_level(warn_lvl),
      .undervoltage_shutdown(uv), .overvoltage_shutdown(ov), .bridge_drive_enable(drive),
      .bridge_float(flt), .output_ramp_to_ground(ramp), .low_power(lowp), .fault_n(fault_n),
      .over_temp_warning_n(warn_n));

   // Inputs move and outputs are read 2 ns after the edge, clear of the sampling point
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // All outputs in one byte: drive, float, ramp, low power, fault, warning
   function automatic logic [7:0] outs();
      return {2'h0, drive, flt, ramp, lowp, fault_n, warn_n};
   endfunction

   // Bounded wait for the bridges to switch again
   task automatic wait_drive(input int lim);
      cnt = 0;
      while (drive !== 1'b1 && cnt < lim) begin
         step(1);
         cnt++;
      end
   endtask

   // Release the amplifier reset and time the start-up against the expected window
   task automatic start_up(input logic sel, input int lo, input int hi);
      cfg = sel;
      want_run = 1'b1;
      step(3);
      check({7'h0, fault_n}, 8'h01);
      wait_drive(hi);
      check({7'h0, (cnt + 3 >= lo) && (cnt + 3 <= hi)}, 8'h01);
      check(outs(), 8'h23);
   endtask

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // A hang is cut short well beyond the few hundred cycles the tests need
   initial begin
      #(40 * 20000);
      n_fail++;
      end_sim();
   end

   initial begin
      step(8);
      resetn = 1'b1;
      step(3);
      check(outs(), 8'h0F);
      start_up(1'b0, BTL, BTL + 5);
      // Float request takes the bridges off at once and gives them back on release
      want_float = 1'b1;
      step(1);
      check(outs(), 8'h13);
      want_float = 1'b0;
      step(2);
      check(outs(), 8'h23);
      // Thermal trip stops drive, stays off the fault pin and clears by itself
      ot_trip = 1'b1;
      step(1);
      check({6'h0, drive, fault_n}, 8'h01);
      ot_trip = 1'b0;
      wait_drive(SE + 10);
      check({7'h0, drive}, 8'h01);
      // Warning follows the temperature flag both ways, no reset cycle
      warn_lvl = 1'b1;
      step(1);
      check({7'h0, warn_n}, 8'h00);
      warn_lvl = 1'b0;
      step(1);
      check({7'h0, warn_n}, 8'h01);
      // Undervoltage then overvoltage; undervoltage also makes the host float early
      for (int i = 0; i < 2; i++) begin
         uv = (i == 0);
         ov = (i == 1);
         step(2);
         check({6'h0, drive, flt}, {7'h0, uv});
         uv = 1'b0;
         ov = 1'b0;
         wait_drive(SE + 10);
         check({7'h0, drive}, 8'h01);
      end
      // One-cycle short latches; thermal recovery must not bring drive back
      short_det = 1'b1;
      step(1);
      short_det = 1'b0;
      check(outs(), 8'h01);
      ot_trip = 1'b1;
      step(3);
      ot_trip = 1'b0;
      step(SE + 10);
      check(outs(), 8'h01);
      // Fault holds through the low phase and clears only on the rising edge
      want_run = 1'b0;
      step(3);
      check(outs(), 8'h0D);
      start_up(1'b1, SE, SE + 5);
      end_sim();
   end
endmodule
